// File: hw/eeprom_cmd_pkg.sv
package eeprom_cmd_pkg;

    // ------------------------------------------------------------
    // geometry and instruction framing
    // ------------------------------------------------------------
    localparam int WORD_W      = 16;
    localparam int ADDR_W      = 4;
    localparam int ADDR_FIELD  = 6;
    localparam int HDR_BITS    = 8;
    localparam int DEPTH       = 16;
    localparam int BITCNT_W    = 5;

    localparam logic [1:0] OP_READ   = 2'h2;
    localparam logic [1:0] OP_WRITE  = 2'h1;
    localparam logic [1:0] OP_MISC   = 2'h0;
    localparam logic [1:0] SUB_WEN   = 2'h3;
    localparam logic [1:0] SUB_WDS   = 2'h0;
    localparam logic [1:0] SUB_WRITE_ALL_CMD = 2'h1;

    // ------------------------------------------------------------
    // timing, at 250 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_PS   = 4000;
    localparam int PROGRAM_TIME_NS = 10000;
    localparam int PROGRAM_CYCLES  = (PROGRAM_TIME_NS * 1000) / CLK_PERIOD_PS;
    localparam int PROG_CNT_W      = 24;

    localparam logic [WORD_W-1:0] MEM_RESET   = 16'hffff;
    localparam logic [ADDR_W-1:0] PROT_RESET  = 4'hf;
    localparam logic              PROT_CLEARED = 1'b1;

    // ------------------------------------------------------------
    // shared carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic                  wr_en;
        logic                  wr_all;
        logic [ADDR_W-1:0]     addr;
        logic [WORD_W-1:0]     data;
    } prog_req_t;

    typedef struct packed {
        logic cs;
        logic sclk_rise;
        logic sdin;
    } link_in_t;

endpackage

// File: hw/link_sampler.sv
`timescale 1ns/1ps
module link_sampler (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // raw pins
    input  wire logic                     cs_pin,
    input  wire logic                     sclk_pin,
    input  wire logic                     sdin_pin,
    // sampled view
    output eeprom_cmd_pkg::link_in_t      link
);

    typedef struct packed {
        logic [2:0] meta;
        logic [2:0] sync;
        logic       sclk_prev;
    } samp_state_t;

    samp_state_t st_r;
    samp_state_t st_nxt;

    always_comb begin
        st_nxt           = st_r;
        st_nxt.meta      = {cs_pin, sclk_pin, sdin_pin};
        st_nxt.sync      = st_r.meta;
        st_nxt.sclk_prev = st_r.sync[1];
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // edges are only taken from synchronised samples
    assign link.cs        = st_r.sync[2];
    assign link.sclk_rise = st_r.sync[1] & ~st_r.sclk_prev;
    assign link.sdin      = st_r.sync[0];

endmodule

// File: hw/prog_engine.sv
`timescale 1ns/1ps
module prog_engine #(
    parameter int PROG_CYCLES = eeprom_cmd_pkg::PROGRAM_CYCLES
) (
    // clock and reset
    input  wire logic                                 clk,
    input  wire logic                                 rst_n,
    // programming request, one-cycle pulse
    input  eeprom_cmd_pkg::prog_req_t                 req,
    // read port
    input  wire logic [eeprom_cmd_pkg::ADDR_W-1:0]    rd_addr,
    output logic      [eeprom_cmd_pkg::WORD_W-1:0]    rd_data,
    // status
    output logic                                      busy
);

    typedef struct packed {
        logic [eeprom_cmd_pkg::PROG_CNT_W-1:0] cnt;
        logic                                  busy;
    } eng_state_t;

    eng_state_t st_r;
    eng_state_t st_nxt;
    logic [eeprom_cmd_pkg::WORD_W-1:0] mem_r [eeprom_cmd_pkg::DEPTH];

    always_comb begin
        st_nxt = st_r;
        if (req.wr_en || req.wr_all) begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt  = eeprom_cmd_pkg::PROG_CNT_W'(PROG_CYCLES - 1);
        end else if (st_r.busy) begin
            if (st_r.cnt == '0) begin
                st_nxt.busy = 1'b0;
            end else begin
                st_nxt.cnt = st_r.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // the array is written at the start of the cycle; busy only models the wait
    genvar gi;
    generate
        for (gi = 0; gi < eeprom_cmd_pkg::DEPTH; gi++) begin : g_word
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[gi] <= eeprom_cmd_pkg::MEM_RESET;
                end else if (req.wr_all ||
                             (req.wr_en && req.addr == eeprom_cmd_pkg::ADDR_W'(gi))) begin
                    mem_r[gi] <= req.data;
                end
            end
        end
    endgenerate

    assign rd_data = mem_r[rd_addr];
    assign busy    = st_r.busy;

endmodule

// File: hw/serial_eeprom.sv
// Functional notes
// - six address bits follow opcode; read/write use low four bits only.
// - other instructions decode upper address bits with opcode and pins.
// - write and write-all carry sixteen data bits, msb first both ways.
// - select low ends a cycle; programming starts there and shows busy.
// - read loads word, sends one dummy zero, then word msb first.
// - output bits change on serial clock rising edges.
// - select held high keeps reading successive words, address incrementing.
// - address pointer wraps from last location to first.
// - dummy zero only before first word of sequential read.
// - powers up write-disabled; write-enable holds until write-disable.
// - write-enable takes effect at select falling edge.
// - reads execute whether write-enabled or not.
// - write needs enable, unprotected address, program-enable high, protect-select low.
// - select falling after last data bit starts timed programming.
// - select high while programming shows busy low, ready high, no clock needed.
// - write-all programs all words; needs protect cleared, enable, pins.
// - write-disable blocks programming, effective at select falling edge.
// - input sampled on rising clock; all ignored while select low.
// - leading zeros skipped; first one is the start bit.
// - after ready, output releases once a start bit is clocked in.
`timescale 1ns/1ps
module serial_eeprom #(
    parameter int PROG_CYCLES = eeprom_cmd_pkg::PROGRAM_CYCLES
) (
    // clock and reset
    input  wire logic REF_CLK,
    input  wire logic RST_N,
    // serial link pins
    input  wire logic CHIP_SELECT,
    input  wire logic SERIAL_CLOCK,
    input  wire logic SERIAL_IN,
    output logic      SERIAL_OUT,
    output logic      SERIAL_OUT_OE,
    // control pins
    input  wire logic PROGRAM_ENABLE_PIN,
    input  wire logic PROTECT_SELECT_PIN
);

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        S_IDLE  = 6'h01,
        S_HDR   = 6'h02,
        S_DATA  = 6'h04,
        S_READ  = 6'h08,
        S_DONE  = 6'h10,
        S_STAT  = 6'h20
    } phase_t;

    typedef struct packed {
        phase_t                                phase;
        logic [eeprom_cmd_pkg::BITCNT_W-1:0]   bitcnt;
        logic [eeprom_cmd_pkg::HDR_BITS-1:0]   hdr;
        logic [eeprom_cmd_pkg::WORD_W-1:0]     shreg;
        logic [eeprom_cmd_pkg::ADDR_W-1:0]     ptr;
        logic                                  first;
        logic                                  wr_enabled;
        logic                                  cs_prev;
        logic [1:0]                            pins_meta;
        logic [1:0]                            pins_sync;
        logic                                  do_val;
        logic                                  do_oe;
        logic                                  stat_shown;
    } ctl_state_t;

    // ------------------------------------------------------------
    // sampling and engine
    // ------------------------------------------------------------
    eeprom_cmd_pkg::link_in_t  link;
    eeprom_cmd_pkg::prog_req_t req;
    logic [eeprom_cmd_pkg::WORD_W-1:0] rd_data;
    logic                              busy;
    ctl_state_t                        st_r;
    ctl_state_t                        st_nxt;
    logic                              cs_fall;
    logic                              cs_rise;
    logic                              pe_ok;
    logic [1:0]                        opc;
    logic [1:0]                        sub;

    link_sampler u_samp (
        .clk      (REF_CLK),
        .rst_n    (RST_N),
        .cs_pin   (CHIP_SELECT),
        .sclk_pin (SERIAL_CLOCK),
        .sdin_pin (SERIAL_IN),
        .link     (link)
    );

    prog_engine #(
        .PROG_CYCLES (PROG_CYCLES)
    ) u_eng (
        .clk     (REF_CLK),
        .rst_n   (RST_N),
        .req     (req),
        .rd_addr (st_r.ptr),
        .rd_data (rd_data),
        .busy    (busy)
    );

    assign cs_fall = st_r.cs_prev & ~link.cs;
    assign cs_rise = ~st_r.cs_prev & link.cs;
    // pins_sync[1] = program enable, [0] = protect select
    assign pe_ok   = st_r.pins_sync[1] & ~st_r.pins_sync[0];
    assign opc     = st_r.hdr[7:6];
    assign sub     = st_r.hdr[5:4];

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    always_comb begin
        st_nxt           = st_r;
        req              = '0;
        st_nxt.cs_prev   = link.cs;
        st_nxt.pins_meta = {PROGRAM_ENABLE_PIN, PROTECT_SELECT_PIN};
        st_nxt.pins_sync = st_r.pins_meta;
        if (!link.cs) begin
            st_nxt.do_oe      = 1'b0;
            st_nxt.phase      = S_IDLE;
            st_nxt.bitcnt     = '0;
            st_nxt.stat_shown = 1'b0;
            if (cs_fall && st_r.phase == S_DONE) begin
                if (opc == eeprom_cmd_pkg::OP_MISC && !st_r.pins_sync[0]) begin
                    if (sub == eeprom_cmd_pkg::SUB_WEN) begin
                        st_nxt.wr_enabled = 1'b1;
                    end else if (sub == eeprom_cmd_pkg::SUB_WDS) begin
                        st_nxt.wr_enabled = 1'b0;
                    end
                end
                // protect register stays at its cleared value, so no address is protected
                if (st_r.wr_enabled && pe_ok && !busy) begin
                    req.addr = st_r.hdr[eeprom_cmd_pkg::ADDR_W-1:0];
                    req.data = st_r.shreg;
                    if (opc == eeprom_cmd_pkg::OP_WRITE) begin
                        req.wr_en = 1'b1;
                    end else if (opc == eeprom_cmd_pkg::OP_MISC &&
                                 sub == eeprom_cmd_pkg::SUB_WRITE_ALL_CMD &&
                                 eeprom_cmd_pkg::PROT_CLEARED) begin
                        req.wr_all = 1'b1;
                    end
                end
            end
        end else if (cs_rise && busy) begin
            st_nxt.phase      = S_STAT;
            st_nxt.do_oe      = 1'b1;
            st_nxt.do_val     = 1'b0;
            st_nxt.stat_shown = 1'b1;
        end else begin
            if (st_r.stat_shown) begin
                st_nxt.do_val = ~busy;
            end
            case (st_r.phase)
                S_STAT: begin
                    if (!busy) begin
                        st_nxt.phase = S_IDLE;
                    end
                end
                S_IDLE: begin
                    if (link.sclk_rise && link.sdin) begin
                        st_nxt.phase      = S_HDR;
                        st_nxt.bitcnt     = '0;
                        st_nxt.do_oe      = 1'b0;
                        st_nxt.stat_shown = 1'b0;
                    end
                end
                S_HDR: begin
                    if (link.sclk_rise) begin
                        st_nxt.hdr    = {st_r.hdr[eeprom_cmd_pkg::HDR_BITS-2:0], link.sdin};
                        st_nxt.bitcnt = st_r.bitcnt + 1'b1;
                        if (st_r.bitcnt ==
                            eeprom_cmd_pkg::BITCNT_W'(eeprom_cmd_pkg::HDR_BITS - 1)) begin
                            st_nxt.bitcnt = '0;
                            if (st_nxt.hdr[7:6] == eeprom_cmd_pkg::OP_READ) begin
                                st_nxt.ptr   = st_nxt.hdr[eeprom_cmd_pkg::ADDR_W-1:0];
                                st_nxt.phase = S_READ;
                                st_nxt.first = 1'b1;
                                st_nxt.do_oe = 1'b1;
                                st_nxt.do_val = 1'b0;
                            end else if (st_nxt.hdr[7:6] == eeprom_cmd_pkg::OP_WRITE ||
                                         (st_nxt.hdr[7:6] == eeprom_cmd_pkg::OP_MISC &&
                                          st_nxt.hdr[5:4] == eeprom_cmd_pkg::SUB_WRITE_ALL_CMD)) begin
                                st_nxt.phase = S_DATA;
                            end else begin
                                st_nxt.phase = S_DONE;
                            end
                        end
                    end
                end
                S_DATA: begin
                    if (link.sclk_rise) begin
                        st_nxt.shreg  = {st_r.shreg[eeprom_cmd_pkg::WORD_W-2:0], link.sdin};
                        st_nxt.bitcnt = st_r.bitcnt + 1'b1;
                        if (st_r.bitcnt ==
                            eeprom_cmd_pkg::BITCNT_W'(eeprom_cmd_pkg::WORD_W - 1)) begin
                            st_nxt.phase = S_DONE;
                        end
                    end
                end
                S_READ: begin
                    if (link.sclk_rise) begin
                        if (st_r.bitcnt == '0) begin
                            st_nxt.shreg  = {rd_data[eeprom_cmd_pkg::WORD_W-2:0], 1'b0};
                            st_nxt.do_val = rd_data[eeprom_cmd_pkg::WORD_W-1];
                        end else begin
                            st_nxt.shreg  = {st_r.shreg[eeprom_cmd_pkg::WORD_W-2:0], 1'b0};
                            st_nxt.do_val = st_r.shreg[eeprom_cmd_pkg::WORD_W-1];
                        end
                        st_nxt.first = 1'b0;
                        if (st_r.bitcnt ==
                            eeprom_cmd_pkg::BITCNT_W'(eeprom_cmd_pkg::WORD_W - 1)) begin
                            st_nxt.bitcnt = '0;
                            st_nxt.ptr    = st_r.ptr + 1'b1;
                        end else begin
                            st_nxt.bitcnt = st_r.bitcnt + 1'b1;
                        end
                    end
                end
                default: begin
                    st_nxt.phase = st_r.phase;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r       <= '0;
            st_r.phase <= S_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign SERIAL_OUT    = st_r.do_val;
    assign SERIAL_OUT_OE = st_r.do_oe;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_idle_when_deselected;
        @(posedge REF_CLK) disable iff (!RST_N)
        !link.cs |=> !SERIAL_OUT_OE;
    endproperty
    a_idle_when_deselected: assert property (p_idle_when_deselected)
        else $error("output driven while deselected");

    property p_dummy_zero;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_r.phase == S_HDR && st_nxt.phase == S_READ) |=> (SERIAL_OUT_OE && !SERIAL_OUT);
    endproperty
    a_dummy_zero: assert property (p_dummy_zero)
        else $error("read did not start with dummy zero");

    property p_busy_low;
        @(posedge REF_CLK) disable iff (!RST_N)
        (link.cs && !st_r.cs_prev && busy) |=> (SERIAL_OUT_OE && !SERIAL_OUT);
    endproperty
    a_busy_low: assert property (p_busy_low)
        else $error("busy not shown low");

    property p_wrap;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_r.phase == S_READ && link.cs && link.sclk_rise && st_r.ptr == 4'hf &&
         st_r.bitcnt == 5'h0f) |=> st_r.ptr == 4'h0;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("pointer did not wrap");

    property p_no_write_disabled;
        @(posedge REF_CLK) disable iff (!RST_N)
        !st_r.wr_enabled |-> !(req.wr_en || req.wr_all);
    endproperty
    a_no_write_disabled: assert property (p_no_write_disabled)
        else $error("write while disabled");

    property p_prog_busy;
        @(posedge REF_CLK) disable iff (!RST_N)
        (req.wr_en || req.wr_all) |=> busy [*2];
    endproperty
    a_prog_busy: assert property (p_prog_busy)
        else $error("programming did not show busy");

    property p_req_at_fall;
        @(posedge REF_CLK) disable iff (!RST_N)
        (req.wr_en || req.wr_all) |-> (cs_fall && pe_ok);
    endproperty
    a_req_at_fall: assert property (p_req_at_fall)
        else $error("programming outside select fall");

    property p_out_changes_on_edge;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_r.phase == S_READ && link.cs && !link.sclk_rise && !cs_rise) |=> $stable(SERIAL_OUT);
    endproperty
    a_out_changes_on_edge: assert property (p_out_changes_on_edge)
        else $error("read output changed without clock edge");

    // later words start straight with their msb, no second dummy bit
    property p_no_later_dummy;
        @(posedge REF_CLK) disable iff (!RST_N)
        (st_r.phase == S_READ && link.cs && link.sclk_rise && !st_r.first &&
         st_r.bitcnt == '0) |=> (SERIAL_OUT == $past(rd_data[eeprom_cmd_pkg::WORD_W-1]));
    endproperty
    a_no_later_dummy: assert property (p_no_later_dummy)
        else $error("dummy bit repeated before a later word");

endmodule

// File: verif/link_master.sv
`timescale 1ns/1ps
module link_master (
    // clock
    input  wire logic clk,
    // link pins
    output logic      cs,
    output logic      sclk,
    output logic      sdin,
    output logic      psel,
    // device answer
    input  wire logic sdo,
    input  wire logic sdo_oe
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    int          half     = 6;
    logic        in_frame = 1'b0;
    logic        first_bit;
    logic [15:0] rx_q[$];

    initial begin
        cs   = 1'b0;
        sclk = 1'b0;
        sdin = 1'b0;
        psel = 1'b0;
    end

    // data line is not held outside frames: keep it moving so no stale value passes
    always @(posedge clk) begin
        if (!in_frame) begin
            sdin <= ~sdin;
        end
    end

    // ------------------------------------------------------------
    // bus cycles
    // ------------------------------------------------------------
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic set_psel(input logic v);
        @(posedge clk);
        psel <= v;
    endtask

    // select edges also park the serial clock low, so no rising edge follows a drop
    task automatic sel(input logic on);
        cs       <= on;
        sclk     <= 1'b0;
        in_frame = on;
        wait_clk(8);
    endtask

    // bit set up in the low phase, taken by the device at the rising edge
    task automatic shift(input logic b, output logic o);
        sclk <= 1'b0;
        sdin <= b;
        wait_clk(half);
        o    = sdo_oe ? sdo : ~sdo;
        sclk <= 1'b1;
        wait_clk(half);
    endtask

    task automatic read_words(input int n);
        logic        o;
        logic [15:0] w;
        shift(1'b0, first_bit);
        repeat (n) begin
            for (int i = 0; i < 16; i++) begin
                shift(1'b0, o);
                w = {w[14:0], o};
            end
            rx_q.push_back(w);
        end
    endtask
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int PROG = 40;

    logic        ref_clk;
    logic        rst_n;
    logic        pe;
    logic        cs;
    logic        sclk;
    logic        sdin;
    logic        psel;
    logic        sdo;
    logic        sdo_oe;
    int          errors    = 0;
    int          tests_run = 0;
    integer      seed      = 32'h937d5ac4;
    logic [15:0] exp_mem[16];
    bit          wen_m = 1'b0;

    always #2 ref_clk = ~ref_clk;

    serial_eeprom #(.PROG_CYCLES(PROG)) serial_eeprom_i (
        .REF_CLK            (ref_clk),
        .RST_N              (rst_n),
        .CHIP_SELECT        (cs),
        .SERIAL_CLOCK       (sclk),
        .SERIAL_IN          (sdin),
        .SERIAL_OUT         (sdo),
        .SERIAL_OUT_OE      (sdo_oe),
        .PROGRAM_ENABLE_PIN (pe),
        .PROTECT_SELECT_PIN (psel)
    );

    link_master link_master_i (
        .clk    (ref_clk),
        .cs     (cs),
        .sclk   (sclk),
        .sdin   (sdin),
        .psel   (psel),
        .sdo    (sdo),
        .sdo_oe (sdo_oe)
    );

    // ------------------------------------------------------------
    // compare and report
    // ------------------------------------------------------------
    task automatic chk_w(input string what, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_b(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask

    task automatic final_report;
        $display("comparisons %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // instruction helpers
    // ------------------------------------------------------------
    task automatic cmd(input int lead, input logic [1:0] op, input logic [5:0] a,
                       input logic [15:0] d, input int nd);
        logic [24:0] v;
        logic        o;
        v = {1'b1, op, a, d};
        link_master_i.sel(1'b1);
        repeat (lead) link_master_i.shift(1'b0, o);
        for (int i = 24; i >= 16 - nd; i--) link_master_i.shift(v[i], o);
    endtask

    // status shows only for a cycle that really started programming
    task automatic poll(input bit go);
        logic o;
        int   n;
        link_master_i.sel(1'b1);
        chk_b("status drive", go, sdo_oe);
        if (go) begin
            chk_b("busy level", 1'b0, sdo);
            n = 0;
            while (sdo !== 1'b1 && n < 200) begin
                @(posedge ref_clk);
                n++;
            end
            if (n >= 200) begin
                errors++;
                final_report();
            end
            link_master_i.shift(1'b1, o);
            link_master_i.wait_clk(6);
            chk_b("status release", 1'b0, sdo_oe);
        end
        link_master_i.sel(1'b0);
    endtask

    task automatic do_prog(input logic [1:0] op, input logic [5:0] a, input logic [15:0] d);
        bit go;
        cmd(0, op, a, d, 16);
        link_master_i.sel(1'b0);
        go = wen_m && pe && !psel;
        if (go && op == eeprom_cmd_pkg::OP_WRITE) exp_mem[a[3:0]] = d;
        if (go && op == eeprom_cmd_pkg::OP_MISC) begin
            foreach (exp_mem[i]) exp_mem[i] = d;
        end
        poll(go);
    endtask

    task automatic misc(input logic [1:0] sub, input int lead);
        cmd(lead, eeprom_cmd_pkg::OP_MISC, {sub, 4'($random(seed))}, 16'h0, 0);
        link_master_i.sel(1'b0);
        if (sub == eeprom_cmd_pkg::SUB_WEN) wen_m = 1'b1;
        if (sub == eeprom_cmd_pkg::SUB_WDS) wen_m = 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input int n);
        cmd(0, eeprom_cmd_pkg::OP_READ, a, 16'h0, 0);
        link_master_i.read_words(n);
        link_master_i.sel(1'b0);
        chk_b("dummy bit", 1'b0, link_master_i.first_bit);
        for (int k = 0; k < n; k++) begin
            chk_w("read word", exp_mem[(int'(a[3:0]) + k) % 16],
                  link_master_i.rx_q.pop_front());
        end
    endtask

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (90000) @(posedge ref_clk);
        errors++;
        final_report();
    end

    initial begin
        ref_clk = 1'b0;
        rst_n   = 1'b0;
        pe      = 1'b1;
        foreach (exp_mem[i]) exp_mem[i] = eeprom_cmd_pkg::MEM_RESET;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        link_master_i.wait_clk(6);
        rd_chk(6'h3e, 17);
        do_prog(eeprom_cmd_pkg::OP_WRITE, 6'h05, 16'h1234);
        misc(eeprom_cmd_pkg::SUB_WEN, 3);
        for (int j = 0; j < 5; j++) begin
            // program enable is random here, so refused writes mix with taken ones
            @(posedge ref_clk);
            pe <= 1'($random(seed));
            do_prog(eeprom_cmd_pkg::OP_WRITE, 6'($random(seed)), 16'($random(seed)));
        end
        @(posedge ref_clk);
        pe <= 1'b0;
        do_prog(eeprom_cmd_pkg::OP_WRITE, 6'h02, 16'h5aa5);
        @(posedge ref_clk);
        pe <= 1'b1;
        link_master_i.set_psel(1'b1);
        do_prog(eeprom_cmd_pkg::OP_WRITE, 6'h03, 16'ha55a);
        link_master_i.set_psel(1'b0);
        rd_chk(6'($random(seed)), 18);
        do_prog(eeprom_cmd_pkg::OP_MISC, {eeprom_cmd_pkg::SUB_WRITE_ALL_CMD, 4'h9},
                16'($random(seed)));
        rd_chk(6'h0c, 16);
        misc(eeprom_cmd_pkg::SUB_WDS, 0);
        do_prog(eeprom_cmd_pkg::OP_WRITE, 6'h07, 16'h0f0f);
        rd_chk(6'h06, 2);
        final_report();
    end
endmodule
